// file: core/adc_autoscan_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - no start while scan select is zero
// - scan select change applies next loop
// - low byte read latches top two bits
// - upper six high bits read zero
// - result registers survive reset
// - reset zeroes control and scan select
// - pin port reads live levels, no reset
// - low power aborts, clears start, halts clock
// - low power leaves done flag alone
// - two-bit prescaler selects divisor m
// - conversion lasts 6m+1 machine cycles
// - two sample, ten bit, one store
// - conversions in loop spaced 7m cycles
// - first sample waits for divided clock
// - ascending scan over set bits only
// - result goes to its channel buffer
// - start by software or selected pin edges
// - done set at loop end, software clears
// - start held pending while done set
// - prescaler codes map to 2,4,6,8
// - starts ignored while running, clear aborts
// - writing one to done does nothing
module adc_autoscan_sequencer
	import adc_scan_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire sfr_req_t   sfr_req,
	output logic      [7:0] sfr_rdata,
	input  wire logic       low_power,
	input  wire logic       irq_enable,
	input  wire logic       ext_start_input,
	input  wire logic [7:0] ana_pin_level,
	input  wire logic [9:0] ana_result,
	output ana_ctrl_t       ana_ctrl,
	output logic            adc_irq
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [1:0]  prescale_q;
	logic        cont_q;
	logic        rise_en_q;
	logic        fall_en_q;
	logic        done_q;
	logic        start_q;
	logic        pending_q;
	logic [7:0]  scan_sel_q;
	logic        ext_q;
	logic [3:0]  mc_cnt_q;
	logic [1:0]  half_cnt_q;
	scan_state_t state_q;
	logic [2:0]  ch_q;
	logic [7:0]  loop_sel_q;
	logic [3:0]  cnt_q;
	logic [9:0]  res_q [8];
	logic [1:0]  hi_q;
	logic [7:0]  pin_q;
	logic [7:0]  rdata_q;

	ctrl_t       wctrl;
	ctrl_t       rctrl;
	logic        wr_ctrl;
	logic        wr_sel;
	logic        rd_low;
	logic [2:0]  rd_idx;
	logic        ext_edge;
	logic        start_req;
	logic        launch;
	logic        abort;
	logic        mc_en;
	logic        tick;
	logic [3:0]  init_last;
	logic [3:0]  first_ch;
	logic [3:0]  next_ch;
	logic        store_evt;
	logic        last_store;
	logic        loop_stop;

	// lowest set bit at or above 'from' (incl) or strictly above it
	function automatic logic [3:0] next_set(input logic [7:0] set, input logic [2:0] from,
		input logic incl);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (set[i] && ((i > int'(from)) || (incl && i == int'(from)))) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : next_set

	////////////////////////////////////////////////////////////////////////////
	// register port decode
	assign wctrl   = ctrl_t'(sfr_req.wdata);
	assign wr_ctrl = sfr_req.wr && sfr_req.addr == ADDR_CTRL;
	assign wr_sel  = sfr_req.wr && sfr_req.addr == ADDR_SCAN_SEL;
	assign rd_low  = sfr_req.rd && sfr_req.addr[7:3] == ADDR_RES_LOW0[7:3];
	assign rd_idx  = sfr_req.addr[2:0];

	// external pin edges, pin is synchronous to mclk
	assign ext_edge  = (ext_start_input && !ext_q && rise_en_q) ||
	                   (!ext_start_input && ext_q && fall_en_q);
	assign start_req = (wr_ctrl && wctrl.start) || ext_edge;

	// a start only fires once done is clear and channels exist
	assign launch = pending_q && !done_q && !start_q && !low_power &&
	                state_q == ST_IDLE && scan_sel_q != 8'h00;
	assign abort  = low_power || (wr_ctrl && !wctrl.start && start_q);

	////////////////////////////////////////////////////////////////////////////
	// control fields, cleared by reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{prescale_q, cont_q, rise_en_q, fall_en_q} <= '0;
			scan_sel_q <= SCAN_SEL_RESET;
			ext_q      <= 1'b0;
		end else begin
			ext_q <= ext_start_input;
			if (wr_ctrl) begin
				prescale_q <= wctrl.prescale;
				cont_q     <= wctrl.cont;
				rise_en_q  <= wctrl.rise_en;
				fall_en_q  <= wctrl.fall_en;
			end
			if (wr_sel) begin
				scan_sel_q <= sfr_req.wdata;
			end
		end
	end

	// done flag: set wins over software clear; writing one is ignored
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			done_q <= CTRL_RESET[4];
		end else if (last_store) begin
			done_q <= 1'b1;
		end else if (wr_ctrl && !wctrl.done) begin
			done_q <= 1'b0;
		end
	end

	// start request latch; a read-modify-write of zero never cancels it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pending_q <= 1'b0;
		end else if (low_power || launch) begin
			pending_q <= 1'b0;
		end else if (start_req && !start_q) begin
			pending_q <= 1'b1;
		end else if (!done_q && scan_sel_q == 8'h00) begin
			pending_q <= 1'b0;
		end
	end

	// effective start/status flag
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			start_q <= CTRL_RESET[3];
		end else if (abort || (last_store && loop_stop)) begin
			start_q <= 1'b0;
		end else if (launch) begin
			start_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// machine cycle and converter clock dividers, frozen in low power
	assign mc_en     = mc_cnt_q == MC_DIV_LAST && !low_power;
	// >= so a smaller new prescale never waits for the half counter to wrap
	assign tick      = mc_en && half_cnt_q >= prescale_q;
	assign init_last = {1'b0, prescale_q, 1'b0};                          // m-2

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mc_cnt_q   <= 4'h0;
			half_cnt_q <= 2'h0;
		end else if (!low_power) begin
			mc_cnt_q <= (mc_cnt_q == MC_DIV_LAST) ? 4'h0 : mc_cnt_q + 4'h1;
			if (tick) begin
				half_cnt_q <= 2'h0;
			end else if (mc_en) begin
				half_cnt_q <= half_cnt_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// autoscan sequencer
	assign first_ch   = next_set(scan_sel_q, 3'h0, 1'b1);
	assign next_ch    = next_set(loop_sel_q, ch_q, 1'b0);
	assign store_evt  = state_q == ST_STORE && mc_en && !abort;
	assign last_store = store_evt && !next_ch[3];
	assign loop_stop  = !cont_q || scan_sel_q == 8'h00;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= ST_IDLE;
			ch_q       <= 3'h0;
			loop_sel_q <= 8'h00;
			cnt_q      <= 4'h0;
		end else if (abort) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (launch) begin
						loop_sel_q <= scan_sel_q;
						ch_q       <= first_ch[2:0];
						state_q    <= ST_ALIGN;
					end
				end
				ST_ALIGN: begin
					// sampling begins on a divided clock edge
					if (tick) begin
						cnt_q   <= 4'h0;
						state_q <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (tick) begin
						if (cnt_q == CONV_TICK_LAST) begin
							state_q <= ST_STORE;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				ST_STORE: begin
					if (mc_en) begin
						cnt_q <= 4'h0;
						if (next_ch[3]) begin
							ch_q    <= next_ch[2:0];
							state_q <= ST_INIT;
						end else if (!loop_stop) begin
							loop_sel_q <= scan_sel_q;
							ch_q       <= first_ch[2:0];
							state_q    <= ST_INIT;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_INIT: begin
					// m-1 cycles here plus store keeps the 7m pitch
					if (mc_en) begin
						if (cnt_q == init_last) begin
							cnt_q   <= 4'h0;
							state_q <= ST_CONV;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result buffers and upper-bit latch, deliberately without reset
	always_ff @(posedge mclk) begin
		if (store_evt) begin
			res_q[ch_q] <= ana_result;
		end
	end

	always_ff @(posedge mclk) begin
		if (rd_low) begin
			hi_q <= res_q[rd_idx][9:8];
		end
	end

	// pin levels follow the pins, untouched by reset
	always_ff @(posedge mclk) begin
		pin_q <= ana_pin_level;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, registered; unmapped addresses read zero
	always_comb begin
		rctrl          = '0;
		rctrl.prescale = prescale_q;
		rctrl.done     = done_q;
		rctrl.start    = start_q;
		rctrl.cont     = cont_q;
		rctrl.rise_en  = rise_en_q;
		rctrl.fall_en  = fall_en_q;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= RDATA_RESET;
		end else if (sfr_req.rd) begin
			if (rd_low) begin
				rdata_q <= res_q[rd_idx][7:0];
			end else begin
				case (sfr_req.addr)
					ADDR_CTRL:     rdata_q <= rctrl;
					ADDR_SCAN_SEL: rdata_q <= scan_sel_q;
					ADDR_RES_HIGH: rdata_q <= {6'h00, hi_q};
					ADDR_PIN_IN:   rdata_q <= pin_q;
					default:       rdata_q <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign sfr_rdata        = rdata_q;
	assign ana_ctrl.channel = ch_q;
	assign ana_ctrl.sample  = state_q == ST_CONV && cnt_q < SAMPLE_TICKS;
	assign ana_ctrl.convert = state_q == ST_CONV && cnt_q >= SAMPLE_TICKS;
	assign ana_ctrl.clk_en  = state_q == ST_CONV && tick;
	assign ana_ctrl.store   = state_q == ST_STORE;
	assign adc_irq          = done_q && irq_enable;

endmodule : adc_autoscan_sequencer

// file: inc/adc_scan_pkg.sv
package adc_scan_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register addresses on the special function register port
	localparam logic [7:0] ADDR_PIN_IN    = 8'hC7;
	localparam logic [7:0] ADDR_RES_LOW0  = 8'hC8; // eight low bytes, C8..CF
	localparam logic [7:0] ADDR_RES_HIGH  = 8'hD6;
	localparam logic [7:0] ADDR_CTRL      = 8'hD7;
	localparam logic [7:0] ADDR_SCAN_SEL  = 8'hE7;

	// reset values
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] SCAN_SEL_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET    = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// timing: oscillator periods per machine cycle, converter bit periods
	localparam int         OSC_PER_MC     = 12;
	localparam logic [3:0] MC_DIV_LAST    = 4'(OSC_PER_MC - 1);
	localparam logic [3:0] SAMPLE_TICKS   = 4'h2;
	localparam logic [3:0] BIT_TICKS      = 4'hA;
	localparam logic [3:0] CONV_TICK_LAST = 4'(SAMPLE_TICKS + BIT_TICKS - 4'h1);

	////////////////////////////////////////////////////////////////////////////
	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] prescale;   // 00:/2 01:/4 10:/6 11:/8
		logic       reserved;   // reads zero
		logic       done;       // scan_done_flag
		logic       start;      // start_status_flag
		logic       cont;       // continuous_scan_select
		logic       rise_en;    // ext_rising_start_enable
		logic       fall_en;    // ext_falling_start_enable
	} ctrl_t;

	// request from the cpu side
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	// steering toward the analog core
	typedef struct packed {
		logic [2:0] channel;
		logic       sample;
		logic       convert;
		logic       clk_en;
		logic       store;
	} ana_ctrl_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ALIGN = 5'b00010,
		ST_CONV  = 5'b00100,
		ST_STORE = 5'b01000,
		ST_INIT  = 5'b10000
	} scan_state_t;

endpackage : adc_scan_pkg

// file: sim/adc_analog_model.sv
`timescale 1ns/1ps
module adc_analog_model
	import adc_scan_pkg::*;
(
	input  wire logic      mclk,
	input  wire ana_ctrl_t ana_ctrl,
	input  wire logic      pin_cmd,
	output logic     [9:0] ana_result,
	output logic           ext_start_input
);
	logic tog_q = 1'b0;
	logic pin_q = 1'b0;

	// start pin changes just after an edge, as a synchronous source would
	always @(posedge mclk) begin
		tog_q <= ~tog_q;
		pin_q <= pin_cmd;
	end
	assign ext_start_input = pin_q;
	// value is only good in the store phase; elsewhere it flips every clock
	assign ana_result = {ana_ctrl.channel[1:0], ana_ctrl.channel, 5'h15}
		^ (ana_ctrl.store ? 10'h000 : {10{tog_q}});
endmodule : adc_analog_model

// file: sim/adc_scan_properties.sv
`timescale 1ns/1ps
module adc_scan_checker
	import adc_scan_pkg::*;
(
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire sfr_req_t   sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic       low_power,
	input wire logic       irq_enable,
	input wire logic [7:0] ana_pin_level,
	input wire ana_ctrl_t  ana_ctrl,
	input wire logic       adc_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [7:0] sel_q;

	// shadow of scan select, written only by the cpu
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			sel_q <= SCAN_SEL_RESET;
		else if (sfr_req.wr && sfr_req.addr == ADDR_SCAN_SEL)
			sel_q <= sfr_req.wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	a_sel_readback: assert property (sfr_req.rd && sfr_req.addr == ADDR_SCAN_SEL
		|=> sfr_rdata == sel_q) else $error("scan select readback differs");
	a_high_zero: assert property (sfr_req.rd && sfr_req.addr == ADDR_RES_HIGH
		|=> sfr_rdata[7:2] == 6'h00) else $error("high result upper bits not zero");
	a_pin_live: assert property (sfr_req.rd && sfr_req.addr == ADDR_PIN_IN
		&& $stable(ana_pin_level) |=> sfr_rdata == $past(ana_pin_level))
		else $error("pin port read wrong");
	a_power_halt: assert property (low_power && $past(low_power)
		|-> !(ana_ctrl.sample || ana_ctrl.convert || ana_ctrl.clk_en))
		else $error("converter active in low power");
	a_irq_gate: assert property (adc_irq |-> irq_enable)
		else $error("interrupt while disabled");
	// the request must track the done bit that a control read shows
	a_irq_follows: assert property (sfr_req.rd && sfr_req.addr == ADDR_CTRL
		&& irq_enable |=> sfr_rdata[4] == $past(adc_irq))
		else $error("interrupt differs from done flag");
	// ticks come on machine cycle edges, so never closer than twelve clocks
	a_tick_space: assert property ($rose(ana_ctrl.clk_en) |=>
		!ana_ctrl.clk_en [*8] ##1 !ana_ctrl.clk_en [*3]) else $error("ticks too close");
	a_store_len: assert property (disable iff (!arst_n || low_power)
		$rose(ana_ctrl.store) |-> ana_ctrl.store [*8] ##1 ana_ctrl.store [*4]
		##1 !ana_ctrl.store) else $error("store phase not one machine cycle");
	a_conv_after_sample: assert property ($rose(ana_ctrl.convert) |-> $past(ana_ctrl.sample))
		else $error("bit phase without sample phase");
	a_chan_hold: assert property (ana_ctrl.convert |-> $stable(ana_ctrl.channel))
		else $error("channel moved during conversion");
endmodule : adc_scan_checker

bind adc_autoscan_sequencer adc_scan_checker u_chk (.mclk(mclk), .arst_n(arst_n),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .low_power(low_power),
	.irq_enable(irq_enable), .ana_pin_level(ana_pin_level), .ana_ctrl(ana_ctrl),
	.adc_irq(adc_irq));

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import adc_scan_pkg::*;
	logic       mclk = 0, arst_n = 0, low_power = 0, irq_enable = 0, pin_cmd = 0;
	sfr_req_t   sfr_req = '0;
	logic [7:0] sfr_rdata, rv, s, pins = 0;
	logic [9:0] ana_result;
	logic       ext_start_input, adc_irq, st_q = 0, sa_q = 0;
	ana_ctrl_t  ana_ctrl;
	int         fails = 0, num_checks = 0, cyc = 0, seed = 87027, t0 = 0, tl = 0;
	int         chq[$], gap[$], cnv[$];

	always #5 mclk = ~mclk;
	adc_autoscan_sequencer u_dut (.mclk(mclk), .arst_n(arst_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .low_power(low_power), .irq_enable(irq_enable),
		.ext_start_input(ext_start_input), .ana_pin_level(pins), .ana_result(ana_result),
		.ana_ctrl(ana_ctrl), .adc_irq(adc_irq));
	adc_analog_model u_ana (.mclk(mclk), .ana_ctrl(ana_ctrl), .pin_cmd(pin_cmd),
		.ana_result(ana_result), .ext_start_input(ext_start_input));

	////////////////////////////////////////////////////////////////////////////
	// log stored channels, store spacing and conversion length; cut hangs;
	// sampled on the falling edge, clear of the state change at the rising one
	always @(negedge mclk) begin
		cyc++;
		if (ana_ctrl.sample && !sa_q)
			t0 = cyc;
		if (ana_ctrl.store && !st_q) begin
			chq.push_back(ana_ctrl.channel);
			gap.push_back(cyc - tl);
			tl = cyc;
		end
		if (!ana_ctrl.store && st_q)
			cnv.push_back(cyc - t0);
		st_q = ana_ctrl.store;
		sa_q = ana_ctrl.sample;
		if (cyc == 60000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk) sfr_req <= '{a, 1'b1, 1'b0, d};
		@(negedge mclk) sfr_req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge mclk) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(negedge mclk) sfr_req.rd <= 1'b0;
		rv = sfr_rdata;
	endtask : rd

	task automatic wait_done();
		rv = 0;
		while (!rv[4])
			rd(ADDR_CTRL);
	endtask : wait_done

	task automatic clr();
		chq.delete();
		gap.delete();
		cnv.delete();
	endtask : clr

	// reference result the analog side hands over for a channel
	function automatic int res(input int c);
		return (c % 4) * 256 + c * 32 + 21;
	endfunction : res

	// compare one finished loop against the reference, then read results back
	task automatic chk_scan(input logic [7:0] sel, input int m);
		int first;
		first = 1;
		for (int c = 0; c < 8; c++) begin
			if (sel[c]) begin
				chk(chq.pop_front(), c);
				chk(cnv.pop_front(), (6 * m + 1) * 12);
				if (!first) chk(gap[0], 7 * m * 12);
				void'(gap.pop_front());
				first = 0;
				rd(8'(ADDR_RES_LOW0 + c));
				chk(rv, res(c) % 256);
				rd(ADDR_RES_HIGH);
				chk(rv, res(c) / 256);
			end
		end
	endtask : chk_scan

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////
	initial begin
		pins = 8'($random(seed));
		repeat (16) @(negedge mclk);
		arst_n = 1;
		rd(ADDR_CTRL);
		chk(rv, 8'h00);
		rd(ADDR_SCAN_SEL);
		chk(rv, 8'h00);
		// pins read only while the converter is quiet
		rd(ADDR_PIN_IN);
		chk(rv, pins);
		wr(ADDR_CTRL, 8'h08);
		repeat (300) @(negedge mclk);
		rd(ADDR_CTRL);
		chk(rv + chq.size(), 0);
		irq_enable = 1;
		// one-time scans at every prescaler setting
		for (int p = 0; p < 4; p++) begin
			s = 8'($random(seed));
			if (s == 0) s = 8'h81;
			clr();
			wr(ADDR_SCAN_SEL, s);
			wr(ADDR_CTRL, 8'(p * 64 + 8));
			wait_done();
			chk(rv, p * 64 + 16);
			chk(adc_irq, 1);
			chk_scan(s, 2 * p + 2);
			wr(ADDR_CTRL, 8'(p * 64));
			wr(ADDR_CTRL, 8'(p * 64 + 16));
			rd(ADDR_CTRL);
			chk(rv, p * 64);
		end
		// continuous scan, new selection mid-loop, then low power
		clr();
		wr(ADDR_SCAN_SEL, 8'h05);
		wr(ADDR_CTRL, 8'h0C);
		wait (ana_ctrl.sample);
		wr(ADDR_SCAN_SEL, 8'h82);
		wait_done();
		chk(rv, 8'h1C);
		wait (chq.size() >= 4);
		foreach (chq[i]) if (i < 4) chk(chq[i], i == 0 ? 0 : i == 1 ? 2 : i == 2 ? 1 : 7);
		wait (ana_ctrl.convert);
		@(negedge mclk) low_power = 1;
		rd(ADDR_CTRL);
		chk(rv, 8'h14);
		low_power = 0;
		clr();
		repeat (1000) @(negedge mclk);
		rd(8'(ADDR_RES_LOW0 + 7));
		chk(rv + chq.size(), res(7) % 256);
		// start while done is set waits for the clear
		wr(ADDR_CTRL, 8'h18);
		rd(ADDR_CTRL);
		chk(rv, 8'h10);
		clr();
		wr(ADDR_CTRL, 8'h00);
		wait_done();
		chk_scan(8'h82, 2);
		// software clear aborts a running scan
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h08);
		wait (ana_ctrl.convert);
		wr(ADDR_CTRL, 8'h00);
		clr();
		repeat (1000) @(negedge mclk);
		rd(ADDR_CTRL);
		chk(rv + chq.size(), 0);
		// every pin edge selection, rising then falling
		for (int e = 0; e < 4; e++) begin
			wr(ADDR_CTRL, 8'(e));
			clr();
			pin_cmd = 1;
			repeat (250) @(negedge mclk);
			chk(chq.size() > 0, e / 2);
			repeat (400) @(negedge mclk);
			wr(ADDR_CTRL, 8'(e));
			clr();
			pin_cmd = 0;
			repeat (250) @(negedge mclk);
			chk(chq.size() > 0, e % 2);
			repeat (400) @(negedge mclk);
		end
		// a reset after the last scan clears control but keeps results and the latch
		@(negedge mclk) arst_n = 0;
		repeat (4) @(negedge mclk);
		arst_n = 1;
		rd(ADDR_RES_HIGH);
		chk(rv, res(7) / 256);
		rd(8'(ADDR_RES_LOW0 + 1));
		chk(rv, res(1) % 256);
		rd(ADDR_CTRL);
		chk(rv, 8'h00);
		print_verdict();
	end
endmodule : testbench
